// File: rtl/gpio_ports_d_e_f.sv
`timescale 1ns/100ps
`include "gpio_def_params.svh"

// Contract
// R1 - Direction bit one drives the pin; zero leaves it high-impedance input.
// R2 - Reset clears all direction bits, so every pin starts as input.
// R3 - Port D data read gives latch for outputs, pin level for inputs.
// R4 - Port E data decoded at its address; read mixes latch and pin by direction.
// R5 - Port F data decoded at its address; read mixes latch and pin by direction.
// R6 - Writes to a data address update every latch bit regardless of direction.
// R7 - Writing an input bit changes only the latch, not the pin readback.
// R8 - Data latches have no reset and keep contents through system reset.
// R9 - Port E LED bits select direct LED drive or standard drive; read/write.
// R10 - LED drive applies only on outputs: LED bit ANDed with direction bit.
// R11 - Port F has its own LED register, gated by port F direction.
// R12 - One config bit hands all port E pins to the display frontplane driver.
// R13 - Software should load a latch before switching its pin to output.
// R14 - Each port has eight independent pins with latch, direction, LED bits; port D here has no LED register and pad_d.led stays zero.
// R15 - Reduced package: software keeps port F direction bits at zero.
// R16 - An enabled peripheral on a port D pin overrides port direction and data.
// R17 - LED registers reset to zero so all pins start with standard drive.
module gpio_ports_d_e_f #(
    parameter int WIDTH = 8
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pin levels, asynchronous to pclk
    input wire logic [WIDTH-1:0] pin_d_in,
    input wire logic [WIDTH-1:0] pin_e_in,
    input wire logic [WIDTH-1:0] pin_f_in,
    // Port D peripheral overrides and display frontplane drive
    input wire gpio_def_pkg::periph_ovr_type periph_d,
    input wire logic [WIDTH-1:0] lcd_frontplane_outputs,
    // Pad controls
    output gpio_def_pkg::pad_ctrl_type pad_d,
    output gpio_def_pkg::pad_ctrl_type pad_e,
    output gpio_def_pkg::pad_ctrl_type pad_f,
    output logic port_e_lcd_select
);

    ////////////////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] port_d_data, port_e_data, port_f_data;
    logic [WIDTH-1:0] port_d_direction, port_e_direction, port_f_direction;
    logic [WIDTH-1:0] port_e_led_enable, port_f_led_enable;
    logic [WIDTH-1:0] second_config_register;
    logic [WIDTH-1:0] sync_d1, sync_d2, sync_e1, sync_e2, sync_f1, sync_f2;
    logic setup;
    logic wr;
    logic [11:0] idx;
    logic mapped;
    logic [WIDTH-1:0] rd_sel;

    assign idx = paddr[13:2];
    assign setup = psel && !penable;
    // Writes land at the completing edge, the one at which the master sees pready
    assign wr = psel && penable && pready && pwrite && mapped;

    function automatic logic [WIDTH-1:0] mix(input logic [WIDTH-1:0] dir,
                                            input logic [WIDTH-1:0] latch,
                                            input logic [WIDTH-1:0] pin);
        mix = (dir & latch) | (~dir & pin); // [R3] [R7]
    endfunction

    function automatic logic hit(input logic [11:0] a);
        hit = (a == `IDX_PORT_D_DATA) || (a == `IDX_PORT_E_DATA) ||
              (a == `IDX_PORT_F_DATA) || (a == `IDX_PORT_D_DIR) ||
              (a == `IDX_PORT_E_DIR) || (a == `IDX_PORT_F_DIR) ||
              (a == `IDX_PORT_E_LED) || (a == `IDX_PORT_F_LED) ||
              (a == `IDX_CONFIG);
    endfunction

    assign mapped = hit(idx) && (paddr[1:0] == 2'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for pin levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_d1 <= 8'h00;
            sync_d2 <= 8'h00;
            sync_e1 <= 8'h00;
            sync_e2 <= 8'h00;
            sync_f1 <= 8'h00;
            sync_f2 <= 8'h00;
        end else begin
            sync_d1 <= pin_d_in;
            sync_d2 <= sync_d1;
            sync_e1 <= pin_e_in;
            sync_e2 <= sync_e1;
            sync_f1 <= pin_f_in;
            sync_f2 <= sync_f1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data latches: no reset, so contents survive a system reset
    always_ff @(posedge pclk) begin
        if (wr && idx == `IDX_PORT_D_DATA) begin
            port_d_data <= pwdata[WIDTH-1:0]; // [R6] [R8] [R14]
        end
        if (wr && idx == `IDX_PORT_E_DATA) begin
            port_e_data <= pwdata[WIDTH-1:0]; // [R4] [R6] [R8]
        end
        if (wr && idx == `IDX_PORT_F_DATA) begin
            port_f_data <= pwdata[WIDTH-1:0]; // [R5] [R6] [R8]
        end
    end

    // Direction, LED and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_d_direction <= `RESET_DIR; // [R2]
            port_e_direction <= `RESET_DIR; // [R2]
            port_f_direction <= `RESET_DIR; // [R2]
            port_e_led_enable <= `RESET_LED; // [R17]
            port_f_led_enable <= `RESET_LED; // [R17]
            second_config_register <= `RESET_CFG;
        end else if (wr) begin
            if (idx == `IDX_PORT_D_DIR) begin
                port_d_direction <= pwdata[WIDTH-1:0];
            end else if (idx == `IDX_PORT_E_DIR) begin
                port_e_direction <= pwdata[WIDTH-1:0];
            end else if (idx == `IDX_PORT_F_DIR) begin
                port_f_direction <= pwdata[WIDTH-1:0];
            end else if (idx == `IDX_PORT_E_LED) begin
                port_e_led_enable <= pwdata[WIDTH-1:0]; // [R9]
            end else if (idx == `IDX_PORT_F_LED) begin
                port_f_led_enable <= pwdata[WIDTH-1:0]; // [R11]
            end else if (idx == `IDX_CONFIG) begin
                second_config_register <= pwdata[WIDTH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rd_sel = 8'h00;
        if (idx == `IDX_PORT_D_DATA) begin
            rd_sel = mix(port_d_direction, port_d_data, sync_d2); // [R3]
        end else if (idx == `IDX_PORT_E_DATA) begin
            rd_sel = mix(port_e_direction, port_e_data, sync_e2); // [R4]
        end else if (idx == `IDX_PORT_F_DATA) begin
            rd_sel = mix(port_f_direction, port_f_data, sync_f2); // [R5]
        end else if (idx == `IDX_PORT_D_DIR) begin
            rd_sel = port_d_direction;
        end else if (idx == `IDX_PORT_E_DIR) begin
            rd_sel = port_e_direction;
        end else if (idx == `IDX_PORT_F_DIR) begin
            rd_sel = port_f_direction;
        end else if (idx == `IDX_PORT_E_LED) begin
            rd_sel = port_e_led_enable;
        end else if (idx == `IDX_PORT_F_LED) begin
            rd_sel = port_f_led_enable;
        end else if (idx == `IDX_CONFIG) begin
            rd_sel = second_config_register;
        end
    end

    // No wait state: answer registered in setup, shown with pready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup && !pwrite && mapped) begin
                prdata <= {24'h00_0000, rd_sel};
            end else if (setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive; pads are registered so outputs come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_d <= '0;
            pad_e <= '0;
            pad_f <= '0;
            port_e_lcd_select <= 1'b0;
        end else begin
            // Peripheral wins over port logic, bit by bit
            pad_d.oe <= (periph_d.enable & periph_d.oe) |
                        (~periph_d.enable & port_d_direction); // [R1] [R16]
            pad_d.out <= (periph_d.enable & periph_d.out) |
                         (~periph_d.enable & port_d_data); // [R16]
            pad_d.led <= 8'h00;
            port_e_lcd_select <= second_config_register[`CFG_LCD_SELECT_BIT]; // [R12]
            if (second_config_register[`CFG_LCD_SELECT_BIT]) begin
                pad_e.oe <= 8'hFF; // [R12]
                pad_e.out <= lcd_frontplane_outputs;
                pad_e.led <= 8'h00;
            end else begin
                pad_e.oe <= port_e_direction; // [R1]
                pad_e.out <= port_e_data;
                pad_e.led <= port_e_led_enable & port_e_direction; // [R10]
            end
            // Software is expected to keep these inputs on the small package
            pad_f.oe <= port_f_direction; // [R1] [R15]
            pad_f.out <= port_f_data;
            pad_f.led <= port_f_led_enable & port_f_direction; // [R10] [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_dir_reset;
        @(posedge pclk) $rose(presetn) |-> port_d_direction == 8'h00 &&
            port_e_direction == 8'h00 && port_f_direction == 8'h00;
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared"); // [R2]

    property p_led_gate_e;
        @(posedge pclk) disable iff (!presetn)
        !second_config_register[`CFG_LCD_SELECT_BIT] |=>
            pad_e.led == $past(port_e_led_enable & port_e_direction);
    endproperty
    a_led_gate_e: assert property (p_led_gate_e) else $error("port E LED gating wrong"); // [R10]

    property p_led_gate_f;
        @(posedge pclk) disable iff (!presetn)
        ##1 1 |-> pad_f.led == $past(port_f_led_enable & port_f_direction);
    endproperty
    a_led_gate_f: assert property (p_led_gate_f) else $error("port F LED gating wrong"); // [R11]

    property p_oe_f;
        @(posedge pclk) disable iff (!presetn)
        ##1 1 |-> pad_f.oe == $past(port_f_direction);
    endproperty
    a_oe_f: assert property (p_oe_f) else $error("port F enable wrong"); // [R1]

    property p_lcd_take;
        @(posedge pclk) disable iff (!presetn)
        second_config_register[`CFG_LCD_SELECT_BIT] |=> pad_e.oe == 8'hFF && port_e_lcd_select;
    endproperty
    a_lcd_take: assert property (p_lcd_take) else $error("LCD handover missing"); // [R12]

    property p_override_d;
        @(posedge pclk) disable iff (!presetn)
        periph_d.enable != 8'h00 |=>
            ((pad_d.oe ^ $past(periph_d.oe)) & $past(periph_d.enable)) == 8'h00 &&
            ((pad_d.out ^ $past(periph_d.out)) & $past(periph_d.enable)) == 8'h00;
    endproperty
    a_override_d: assert property (p_override_d) else $error("port D override lost"); // [R16]

    property p_write_latch;
        @(posedge pclk) disable iff (!presetn)
        wr && idx == `IDX_PORT_E_DATA |=> port_e_data == $past(pwdata[7:0]);
    endproperty
    a_write_latch: assert property (p_write_latch) else $error("latch not written"); // [R6]

    property p_read_d;
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && idx == `IDX_PORT_D_DATA && paddr[1:0] == 2'h0 |=>
            pready && prdata[7:0] == $past(mix(port_d_direction, port_d_data, sync_d2));
    endproperty
    a_read_d: assert property (p_read_d) else $error("port D readback wrong"); // [R3]

    property p_led_reset;
        @(posedge pclk) $rose(presetn) |-> port_e_led_enable == 8'h00 &&
            port_f_led_enable == 8'h00;
    endproperty
    a_led_reset: assert property (p_led_reset) else $error("LED not cleared"); // [R17]

endmodule

// File: rtl/gpio_def_params.svh
`ifndef GPIO_DEF_PARAMS_SVH
`define GPIO_DEF_PARAMS_SVH

// Printed offsets are register indices; byte address is four times the index
`define IDX_PORT_D_DATA 12'h003
`define IDX_PORT_D_DIR 12'h007
`define IDX_PORT_E_DATA 12'h008
`define IDX_PORT_F_DATA 12'h00A
`define IDX_PORT_E_DIR 12'h00C
`define IDX_PORT_F_DIR 12'h00D
`define IDX_PORT_E_LED 12'h00E
`define IDX_PORT_F_LED 12'h00F
`define IDX_CONFIG 12'h010
`define CFG_LCD_SELECT_BIT 0
`define RESET_DIR 8'h00
`define RESET_LED 8'h00
`define RESET_CFG 8'h00

`endif

// File: rtl/gpio_def_pkg.sv
package gpio_def_pkg;

    // Pad control for one 8-bit port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] led;
    } pad_ctrl_type;

    // Peripheral override request for port D
    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] out;
        logic [7:0] oe;
    } periph_ovr_type;

endpackage

// File: tb/testbench.sv
`timescale 1ns/100ps
`include "gpio_def_params.svh"

module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, lcd_sel;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] pin_d_in, pin_e_in, pin_f_in, lcd_fp;
    gpio_def_pkg::periph_ovr_type periph_d;
    gpio_def_pkg::pad_ctrl_type pad_d, pad_e, pad_f;
    gpio_def_pkg::pad_ctrl_type pads [3];
    logic [11:0] dat_idx [3] = '{`IDX_PORT_D_DATA, `IDX_PORT_E_DATA, `IDX_PORT_F_DATA};
    logic [11:0] dir_idx [3] = '{`IDX_PORT_D_DIR, `IDX_PORT_E_DIR, `IDX_PORT_F_DIR};
    logic [7:0] dval [3] = '{8'hA5, 8'h5A, 8'hC3};
    logic [7:0] dirv [3] = '{8'hF0, 8'h0F, 8'h99};
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    gpio_ports_d_e_f gpio_ports_d_e_f_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_d_in(pin_d_in), .pin_e_in(pin_e_in),
        .pin_f_in(pin_f_in), .periph_d(periph_d), .lcd_frontplane_outputs(lcd_fp),
        .pad_d(pad_d), .pad_e(pad_e), .pad_f(pad_f), .port_e_lcd_select(lcd_sel));

    assign pads[0] = pad_d;
    assign pads[1] = pad_e;
    assign pads[2] = pad_f;

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Hang guard, well above the length of the sequence below
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen at a rising edge; data taken there
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the hang guard ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reg_write(input logic [11:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic reg_read(input logic [11:0] idx);
        xfer(1'b0, idx, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {pin_d_in, pin_e_in, pin_f_in} = {3{8'h66}};
        periph_d = '0;
        lcd_fp = 8'h81;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            reg_read(dir_idx[p]);
            chk(rd, 32'h0);
            chk(pads[p].oe, 8'h00);
        end
        reg_read(`IDX_PORT_E_LED);
        chk(rd, 32'h0);
        // Latch loaded before the pin turns to output, and written twice
        for (int p = 0; p < 3; p++) begin
            reg_write(dat_idx[p], ~dval[p]);
            reg_write(dir_idx[p], dirv[p]);
            reg_write(dat_idx[p], dval[p]);
        end
        repeat (4) @(posedge pclk);
        for (int p = 0; p < 3; p++) begin
            reg_read(dat_idx[p]);
            chk(rd, {24'h0, (dval[p] & dirv[p]) | (8'h66 & ~dirv[p])});
            chk(pads[p].out, dval[p]);
            chk(pads[p].oe, dirv[p]);
        end
        reg_write(`IDX_PORT_E_LED, 8'hFF);
        reg_write(`IDX_PORT_F_LED, 8'hFF);
        reg_read(`IDX_PORT_E_LED);
        chk(rd, 32'hFF);
        reg_read(`IDX_PORT_F_LED);
        chk(rd, 32'hFF);
        repeat (2) @(posedge pclk);
        chk(pad_e.led, 8'h0F);
        chk(pad_f.led, 8'h99);
        chk(pad_d.led, 8'h00);
        // Peripheral takes the low nibble of port D
        periph_d <= '{8'h0F, 8'h03, 8'h05};
        repeat (3) @(posedge pclk);
        chk(pad_d.oe, 8'hF5);
        chk(pad_d.out, 8'hA3);
        reg_write(`IDX_CONFIG, 8'h01);
        repeat (2) @(posedge pclk);
        chk(lcd_sel, 1'b1);
        chk(pad_e, {8'h81, 8'hFF, 8'h00});
        reg_write(`IDX_CONFIG, 8'h00);
        repeat (2) @(posedge pclk);
        chk(pad_e.oe, 8'h0F);
        reg_read(12'h001);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Second reset in mid-run: latches must survive it
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reg_read(`IDX_PORT_F_DIR);
        chk(rd, 32'h0);
        reg_read(`IDX_PORT_F_LED);
        chk(rd, 32'h0);
        reg_write(`IDX_PORT_D_DIR, 8'hFF);
        reg_read(`IDX_PORT_D_DATA);
        chk(rd, 32'hA5);
        // Port F left as inputs with its pins held low, as on the small package
        pin_f_in <= 8'h00;
        repeat (3) @(posedge pclk);
        reg_read(`IDX_PORT_F_DATA);
        chk(rd, 32'h0);
        chk(pad_f.oe, 8'h00);
        give_verdict();
    end
endmodule
